// ### rtl/lpwk_pkg.sv
package lpwk_pkg;

   // =====================================================================
   // register map (word offsets in bytes on the plain port)
   // =====================================================================
   localparam logic [7:0] power_control_reg_off          = 8'h00;
   localparam logic [7:0] deep_powerdown_control_reg_off = 8'h14;
   localparam logic [7:0] retained_general_reg_base      = 8'h04;
   localparam logic [7:0] pin_wake_enable_reg_off        = 8'h20;
   localparam logic [7:0] internal_wake_enable_reg_off   = 8'h24;
   localparam logic [7:0] sleep_power_config_reg_off     = 8'h28;
   localparam logic [7:0] brownout_control_reg_off       = 8'h2c;
   localparam logic [7:0] watchdog_mode_reg_off          = 8'h30;
   localparam logic [7:0] timer_control_reg_off          = 8'h34;
   localparam logic [7:0] timer_count_reg_off            = 8'h38;
   localparam logic [7:0] status_reg_off                 = 8'h3c;

   // =====================================================================
   // field positions
   // =====================================================================
   localparam int power_control_reg_block_bit    = 3;
   localparam int power_control_reg_sleep_flag   = 8;
   localparam int power_control_reg_dpd_flag     = 11;
   localparam int dpd_wake_pin_en   = 0;
   localparam int dpd_lposc_en      = 1;
   localparam int dpd_lposc_keep    = 2;
   localparam int iwe_bod           = 0;
   localparam int iwe_wdt           = 1;
   localparam int iwe_timer         = 2;
   localparam int iwe_serial        = 3;
   localparam int spc_bod_on        = 0;
   localparam int spc_watchdog_oscillator_on      = 1;
   localparam int bod_irq_en        = 0;
   localparam int bod_rst_en        = 1;
   localparam int wdm_run           = 0;
   localparam int wdm_irq_en        = 1;
   localparam int wdm_rst_en        = 2;
   localparam int tc_lp_clock       = 0;

   // =====================================================================
   // reset values and counts
   // =====================================================================
   localparam logic [31:0] reg_reset     = 32'h0000_0000;
   localparam int          num_gp        = 4;
   localparam int          wake_sync_len = 2;
   localparam logic [3:0]  reboot_cycles = 4'h8;
   localparam logic [9:0]  outs_reset    = 10'h033; // core, peripherals, retention, pins on

   // power mode field encodings
   typedef enum logic [2:0] {
      lpwk_pm_active   = 3'h0,
      lpwk_pm_dsleep   = 3'h1,
      lpwk_pm_pdown    = 3'h2,
      lpwk_pm_dpdown   = 3'h3
   } lpwk_pm_type;

   // sequencer states
   typedef enum logic [2:0] {
      lpwk_st_active   = 3'h0,
      lpwk_st_sleep    = 3'h1,
      lpwk_st_dsleep   = 3'h2,
      lpwk_st_pdown    = 3'h3,
      lpwk_st_dpdown   = 3'h4,
      lpwk_st_reboot   = 3'h5
   } lpwk_state_type;

endpackage : lpwk_pkg

// ### rtl/lpwk_sync_if.sv
`timescale 1ns/1ps
// carries the raw wake pin in and its synchronised level out
interface lpwk_sync_if;
   logic raw;    // asynchronous-origin level
   logic synced; // level after two flops
   modport user (output raw, input synced);
   modport sync (input raw, output synced);
endinterface : lpwk_sync_if

// ### rtl/lpwk_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser; the wake pin idles high so reset value is one
module lpwk_sync
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic resetn,
   // signal pair
   lpwk_sync_if.sync sif
);
   typedef struct packed {
      logic s1; // first stage, read only by s2
      logic s2; // second stage
   } lpwk_sync_state_type;

   lpwk_sync_state_type st_q;
   lpwk_sync_state_type st_d;

   // =====================================================================
   // next state
   // =====================================================================
   always_comb
   begin
      st_d    = st_q;
      st_d.s1 = sif.raw;
      st_d.s2 = st_q.s1;
   end

   // registers; pulled-high pin idles at one
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q <= 2'h3;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign sif.synced = st_q.s2;
endmodule : lpwk_sync

// ### rtl/lpwk_ctrl.sv
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module lpwk_ctrl
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // core side
   input  wire logic        core_wfi,
   input  wire logic        core_sleepdeep,
   input  wire logic        core_irq_pending,
   input  wire logic [7:0]  pin_irq,
   input  wire logic        bod_irq,
   input  wire logic        bod_rst,
   input  wire logic        wdt_irq,
   input  wire logic        wdt_rst,
   input  wire logic        serial_irq,
   input  wire logic        serial_slave_ext_clk,
   // wake pin
   input  wire logic        wake_pin,
   // power and clock gating
   output logic             core_clk_en,
   output logic             periph_clk_en,
   output logic             flash_standby,
   output logic             flash_power_off,
   output logic             sram_retain,
   output logic             pin_functions_en,
   output logic             lposc_run,
   output logic             wake_timer_run,
   output logic             wake_event,
   output logic             reboot_req
);

   // =====================================================================
   // state
   // =====================================================================
   typedef struct packed {
      lpwk_pkg::lpwk_state_type st;         // sequencer state
      logic [2:0]               pm;         // power mode field
      logic                     block;      // deep power-down block bit
      logic                     sleep_flag; // low power entered flag
      logic                     dpd_flag;   // deep power-down entered flag
      logic [31:0]              dpd_ctrl;   // deep power-down control
      logic [127:0]             gp;         // retained general registers
      logic [7:0]               pin_we;     // pin wake enables
      logic [7:0]               int_we;     // internal wake enables
      logic [7:0]               spc;        // sleep power config
      logic [7:0]               bod_ctrl;   // brownout control
      logic [7:0]               wdm;        // watchdog mode
      logic [7:0]               tctrl;      // timer control
      logic [31:0]              tcount;     // timer countdown
      logic                     timer_irq;  // timer expired flag
      logic [3:0]               rb_cnt;     // reboot hold counter
      logic [31:0]              rdata;      // read data
      logic [9:0]               outs;       // registered outputs
      logic                     pin_prev;   // last synced wake pin level
   } lpwk_ctrl_state_type;

   lpwk_ctrl_state_type q;
   lpwk_ctrl_state_type d;

   // synchronised wake pin; the edge detector reads the second stage only
   lpwk_sync_if wsif ();
   logic        pin_fall;    // low-going edge seen

   assign wsif.raw = wake_pin;

   lpwk_sync u_sync (.sys_clk(sys_clk), .resetn(resetn), .sif(wsif));

   // previous level resets high like the pulled-up pin, so reset makes no false edge
   assign pin_fall = q.pin_prev & ~wsif.synced;

   // =====================================================================
   // wake qualification
   // =====================================================================
   logic w_pin;   // pin interrupt qualified
   logic w_bodi;  // brownout interrupt
   logic w_bodr;  // brownout reset
   logic w_wdti;  // watchdog interrupt
   logic w_wdtr;  // watchdog reset
   logic w_tmr;   // timer interrupt
   logic w_ser;   // serial peripheral
   logic w_deep;  // any deep-sleep / power-down wake
   logic w_dpd;   // deep power-down wake
   logic tmr_ok;  // timer can count

   always_comb
   begin
      w_pin  = |(pin_irq & q.pin_we);
      w_bodi = bod_irq & q.int_we[lpwk_pkg::iwe_bod]
               & q.bod_ctrl[lpwk_pkg::bod_irq_en] & q.spc[lpwk_pkg::spc_bod_on];
      w_bodr = bod_rst & q.bod_ctrl[lpwk_pkg::bod_rst_en]
               & q.spc[lpwk_pkg::spc_bod_on];
      w_wdti = wdt_irq & q.wdm[lpwk_pkg::wdm_run] & q.wdm[lpwk_pkg::wdm_irq_en]
               & q.spc[lpwk_pkg::spc_watchdog_oscillator_on] & q.int_we[lpwk_pkg::iwe_wdt];
      w_wdtr = wdt_rst & q.wdm[lpwk_pkg::wdm_run] & q.wdm[lpwk_pkg::wdm_rst_en]
               & q.spc[lpwk_pkg::spc_watchdog_oscillator_on];
      w_tmr  = q.timer_irq & q.int_we[lpwk_pkg::iwe_timer];
      w_ser  = serial_irq & serial_slave_ext_clk & q.int_we[lpwk_pkg::iwe_serial];
      w_deep = w_pin | w_bodi | w_bodr | w_wdti | w_wdtr | w_tmr | w_ser;
      // only the pin and the timer can end deep power-down
      w_dpd  = (pin_fall & q.dpd_ctrl[lpwk_pkg::dpd_wake_pin_en])
               | q.timer_irq;
      // timer needs the low-power oscillator selected and enabled
      tmr_ok = q.dpd_ctrl[lpwk_pkg::dpd_lposc_en] & q.tctrl[lpwk_pkg::tc_lp_clock];
      if (q.st == lpwk_pkg::lpwk_st_dpdown)
      begin
         tmr_ok = tmr_ok & q.dpd_ctrl[lpwk_pkg::dpd_lposc_keep];
      end
   end

   // =====================================================================
   // next state
   // =====================================================================
   always_comb
   begin
      d       = q;
      d.rdata = 32'h0000_0000;
      d.pin_prev = wsif.synced;

      // timer countdown; expiry is a sticky flag until a deep-sleep, power-down or deep power-down wake or a write of the count register clears it
      if (tmr_ok && q.tcount != 32'h0000_0000)
      begin
         d.tcount    = q.tcount - 32'h0000_0001;
         d.timer_irq = q.timer_irq | (q.tcount == 32'h0000_0001);
      end

      // register writes
      if (reg_wr)
      begin
         case (reg_addr)
            lpwk_pkg::power_control_reg_off:
            begin
               d.pm = reg_wdata[2:0];
               // block bit only sets; flags clear on a one and an entry below sets again
               d.block      = q.block | reg_wdata[lpwk_pkg::power_control_reg_block_bit];
               d.sleep_flag = q.sleep_flag & ~reg_wdata[lpwk_pkg::power_control_reg_sleep_flag];
               d.dpd_flag   = q.dpd_flag & ~reg_wdata[lpwk_pkg::power_control_reg_dpd_flag];
            end
            lpwk_pkg::deep_powerdown_control_reg_off: d.dpd_ctrl = reg_wdata;
            lpwk_pkg::pin_wake_enable_reg_off:        d.pin_we   = reg_wdata[7:0];
            lpwk_pkg::internal_wake_enable_reg_off:   d.int_we   = reg_wdata[7:0];
            lpwk_pkg::sleep_power_config_reg_off:     d.spc      = reg_wdata[7:0];
            lpwk_pkg::brownout_control_reg_off:       d.bod_ctrl = reg_wdata[7:0];
            lpwk_pkg::watchdog_mode_reg_off:          d.wdm      = reg_wdata[7:0];
            lpwk_pkg::timer_control_reg_off:          d.tctrl    = reg_wdata[7:0];
            lpwk_pkg::timer_count_reg_off:
            begin
               d.tcount    = reg_wdata;
               d.timer_irq = 1'b0;
            end
            default:
            begin
               // general registers sit at 0x04..0x10
               for (int i = 0; i < lpwk_pkg::num_gp; i++)
               begin
                  if (reg_addr == 8'(lpwk_pkg::retained_general_reg_base + 8'(4 * i)))
                  begin
                     d.gp[i*32 +: 32] = reg_wdata;
                  end
               end
            end
         endcase
      end

      // register reads, answered the cycle after the strobe
      if (reg_rd)
      begin
         case (reg_addr)
            lpwk_pkg::power_control_reg_off:
               d.rdata = {20'h00000, q.dpd_flag, 2'h0, q.sleep_flag, 4'h0, q.block, q.pm};
            lpwk_pkg::deep_powerdown_control_reg_off: d.rdata = q.dpd_ctrl;
            lpwk_pkg::pin_wake_enable_reg_off:        d.rdata = {24'h000000, q.pin_we};
            lpwk_pkg::internal_wake_enable_reg_off:   d.rdata = {24'h000000, q.int_we};
            lpwk_pkg::sleep_power_config_reg_off:     d.rdata = {24'h000000, q.spc};
            lpwk_pkg::brownout_control_reg_off:       d.rdata = {24'h000000, q.bod_ctrl};
            lpwk_pkg::watchdog_mode_reg_off:          d.rdata = {24'h000000, q.wdm};
            lpwk_pkg::timer_control_reg_off:          d.rdata = {24'h000000, q.tctrl};
            lpwk_pkg::timer_count_reg_off:            d.rdata = q.tcount;
            lpwk_pkg::status_reg_off:
               d.rdata = {27'h0000000, q.timer_irq, 1'b0, q.st};
            default:
            begin
               // general registers at 0x04..0x10 read back; unmapped addresses read as zero
               for (int i = 0; i < lpwk_pkg::num_gp; i++)
               begin
                  if (reg_addr == 8'(lpwk_pkg::retained_general_reg_base + 8'(4 * i)))
                  begin
                     d.rdata = q.gp[i*32 +: 32];
                  end
               end
            end
         endcase
      end

      // sequencer
      case (q.st)
         lpwk_pkg::lpwk_st_active:
         begin
            if (core_wfi)
            begin
               if (!core_sleepdeep)
               begin
                  d.st = lpwk_pkg::lpwk_st_sleep;
                  d.sleep_flag = 1'b1;
               end
               else
               begin
                  case (q.pm)
                     lpwk_pkg::lpwk_pm_dsleep:
                     begin
                        d.st = lpwk_pkg::lpwk_st_dsleep;
                        d.sleep_flag = 1'b1;
                     end
                     lpwk_pkg::lpwk_pm_pdown:
                     begin
                        d.st = lpwk_pkg::lpwk_st_pdown;
                        d.sleep_flag = 1'b1;
                     end
                     lpwk_pkg::lpwk_pm_dpdown:
                     begin
                        // blocked deep power-down falls back to sleep
                        if (q.block)
                        begin
                           d.st = lpwk_pkg::lpwk_st_sleep;
                           d.sleep_flag = 1'b1;
                        end
                        else
                        begin
                           d.st = lpwk_pkg::lpwk_st_dpdown;
                           d.dpd_flag = 1'b1;
                        end
                     end
                     default:
                     begin
                        d.st = lpwk_pkg::lpwk_st_sleep;
                        d.sleep_flag = 1'b1;
                     end
                  endcase
               end
            end
         end
         lpwk_pkg::lpwk_st_sleep:
         begin
            if (core_irq_pending)
               d.st = lpwk_pkg::lpwk_st_active;
         end
         lpwk_pkg::lpwk_st_dsleep, lpwk_pkg::lpwk_st_pdown:
         begin
            if (w_deep)
            begin
               d.st = lpwk_pkg::lpwk_st_active;
               d.timer_irq = 1'b0;
            end
         end
         lpwk_pkg::lpwk_st_dpdown:
         begin
            if (w_dpd)
            begin
               d.st = lpwk_pkg::lpwk_st_reboot;
               d.rb_cnt = lpwk_pkg::reboot_cycles;
               d.timer_irq = 1'b0;
            end
         end
         lpwk_pkg::lpwk_st_reboot:
         begin
            // power mode, wake enables, sleep config, brownout and watchdog control go back to reset; the rest keeps its value
            d.rb_cnt = q.rb_cnt - 4'h1;
            if (q.rb_cnt == 4'h1)
            begin
               d.st       = lpwk_pkg::lpwk_st_active;
               d.pm       = 3'h0;
               d.pin_we   = 8'h00;
               d.int_we   = 8'h00;
               d.spc      = 8'h00;
               d.bod_ctrl = 8'h00;
               d.wdm      = 8'h00;
            end
         end
         default: d.st = lpwk_pkg::lpwk_st_active;
      endcase

      // registered gating outputs from the next state
      d.outs[0] = (d.st == lpwk_pkg::lpwk_st_active);
      d.outs[1] = (d.st == lpwk_pkg::lpwk_st_active) ||
                  (d.st == lpwk_pkg::lpwk_st_sleep);
      d.outs[2] = (d.st == lpwk_pkg::lpwk_st_dsleep);
      d.outs[3] = (d.st == lpwk_pkg::lpwk_st_pdown) ||
                  (d.st == lpwk_pkg::lpwk_st_dpdown);
      d.outs[4] = (d.st != lpwk_pkg::lpwk_st_dpdown);
      d.outs[5] = (d.st != lpwk_pkg::lpwk_st_dpdown);
      d.outs[6] = d.dpd_ctrl[lpwk_pkg::dpd_lposc_en] &&
                  ((d.st != lpwk_pkg::lpwk_st_dpdown) ||
                   d.dpd_ctrl[lpwk_pkg::dpd_lposc_keep]);
      d.outs[7] = d.outs[6] && d.tctrl[lpwk_pkg::tc_lp_clock] &&
                  (d.tcount != 32'h0000_0000);
      d.outs[8] = (d.st == lpwk_pkg::lpwk_st_active) &&
                  (q.st != lpwk_pkg::lpwk_st_active);
      d.outs[9] = (d.st == lpwk_pkg::lpwk_st_reboot);
   end

   // state register; retained registers reset only with everything else
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         q          <= '0;
         q.st       <= lpwk_pkg::lpwk_st_active;
         q.outs     <= lpwk_pkg::outs_reset;
         q.pin_prev <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // =====================================================================
   // outputs straight from flops
   // =====================================================================
   assign reg_rdata        = q.rdata;
   assign core_clk_en      = q.outs[0];
   assign periph_clk_en    = q.outs[1];
   assign flash_standby    = q.outs[2];
   assign flash_power_off  = q.outs[3];
   assign sram_retain      = q.outs[4];
   assign pin_functions_en = q.outs[5];
   assign lposc_run        = q.outs[6];
   assign wake_timer_run   = q.outs[7];
   assign wake_event       = q.outs[8];
   assign reboot_req       = q.outs[9];

endmodule : lpwk_ctrl

// ### bench/lpwk_ctrl_properties.sv
`timescale 1ns/1ps
// =========================================================
// checker of the sequencer outputs against wake causes
module lpwk_ctrl_chk
(
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       resetn,
   // causes
   input wire logic       core_wfi,
   input wire logic       core_irq_pending,
   input wire logic [7:0] pin_irq,
   input wire logic       bod_irq,
   input wire logic       bod_rst,
   input wire logic       wdt_irq,
   input wire logic       wdt_rst,
   input wire logic       serial_irq,
   // gating and wake outputs
   input wire logic       core_clk_en,
   input wire logic       periph_clk_en,
   input wire logic       flash_standby,
   input wire logic       flash_power_off,
   input wire logic       sram_retain,
   input wire logic       pin_functions_en,
   input wire logic       wake_timer_run,
   input wire logic       wake_event,
   input wire logic       reboot_req
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // any source that may legally end a low power state
   logic any_src;
   assign any_src = core_irq_pending | (|pin_irq) | bod_irq | bod_rst | wdt_irq | wdt_rst
                    | serial_irq | wake_timer_run;
   // reboot hold then return with a wake pulse
   sequence hold8; reboot_req [*8]; endsequence
   sequence back_up; !reboot_req ##[0:1] wake_event; endsequence
   // =========================================================
   // assertions
   wake_active_a: assert property (wake_event |-> (core_clk_en && periph_clk_en) ##1 !wake_event)
      else $error("wake pulse without active clocks");
   pdown_flash_a: assert property (flash_power_off && pin_functions_en |-> !periph_clk_en && sram_retain)
      else $error("power-down gating wrong");
   dsleep_gate_a: assert property (flash_standby |-> !periph_clk_en && !core_clk_en && sram_retain)
      else $error("deep-sleep gating wrong");
   sleep_core_a: assert property (!core_clk_en && periph_clk_en && !reboot_req
      |-> sram_retain && pin_functions_en && !flash_standby && !flash_power_off)
      else $error("sleep touched more than the core");
   dpd_pins_a: assert property (!pin_functions_en && !reboot_req
      |-> !sram_retain && !core_clk_en && !periph_clk_en)
      else $error("deep power-down left parts alive");
   reboot_len_a: assert property ($rose(reboot_req) |-> hold8 ##1 back_up)
      else $error("reboot hold length wrong");
   reboot_src_a: assert property ($rose(reboot_req) |-> $past(pin_functions_en) == 1'b0)
      else $error("reboot outside deep power-down");
   entry_wfi_a: assert property ($fell(core_clk_en) |-> $past(core_wfi))
      else $error("core stopped without wait-for-interrupt");
   wake_cause_a: assert property ($rose(core_clk_en) && !$past(reboot_req)
      |-> $past(any_src) || $past(any_src, 2))
      else $error("wake without a source");
endmodule : lpwk_ctrl_chk

bind lpwk_ctrl lpwk_ctrl_chk i_chk (.sys_clk(sys_clk), .resetn(resetn), .core_wfi(core_wfi),
   .core_irq_pending(core_irq_pending), .pin_irq(pin_irq), .bod_irq(bod_irq), .bod_rst(bod_rst),
   .wdt_irq(wdt_irq), .wdt_rst(wdt_rst), .serial_irq(serial_irq), .core_clk_en(core_clk_en),
   .periph_clk_en(periph_clk_en), .flash_standby(flash_standby), .flash_power_off(flash_power_off),
   .sram_retain(sram_retain), .pin_functions_en(pin_functions_en),
   .wake_timer_run(wake_timer_run), .wake_event(wake_event), .reboot_req(reboot_req));

// ### bench/lpwk_core_model.sv
`timescale 1ns/1ps
// =========================================================
// core and wake sources facing the sequencer
module lpwk_core_model
(
   // clock and core gating
   input wire logic  sys_clk,
   input wire logic  core_clk_en,
   // core requests and sources
   output logic       core_wfi,
   output logic       core_sleepdeep,
   output logic       core_irq_pending,
   output logic [7:0] pin_irq,
   output logic       bod_irq,
   output logic       bod_rst,
   output logic       wdt_irq,
   output logic       wdt_rst,
   output logic       serial_irq,
   output logic       serial_slave_ext_clk,
   output logic       wake_pin
);
   // wake pin idles high through its pull-up
   initial {core_wfi, core_sleepdeep, core_irq_pending, pin_irq, bod_irq, bod_rst, wdt_irq,
            wdt_rst, serial_irq, serial_slave_ext_clk, wake_pin} = 18'h00001;
   // only a clocked core can run wait-for-interrupt
   task automatic wfi(input logic d);
      wait (core_clk_en === 1'b1);
      @(posedge sys_clk) {core_wfi, core_sleepdeep} <= {1'b1, d};
      @(posedge sys_clk) core_wfi <= 1'b0;
   endtask : wfi
   // level sources, slave flag with them
   task automatic set_src(input logic [7:0] p, input logic [6:0] s);
      @(posedge sys_clk) pin_irq <= p;
      {core_irq_pending, bod_irq, bod_rst, wdt_irq, wdt_rst, serial_irq, serial_slave_ext_clk} <= s;
   endtask : set_src
   // low-going pulse, long enough for the two-flop synchroniser
   task automatic pin_pulse();
      @(posedge sys_clk) wake_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      wake_pin <= 1'b1;
   endtask : pin_pulse
endmodule : lpwk_core_model

// ### bench/tb_lpwk_ctrl.sv
`timescale 1ns/1ps
// =========================================================
// bench for the power mode sequencer
module tb_lpwk_ctrl;
   logic sys_clk, resetn, reg_wr, reg_rd, core_wfi, core_sleepdeep, core_irq_pending;
   logic bod_irq, bod_rst, wdt_irq, wdt_rst, serial_irq, serial_slave_ext_clk, wake_pin;
   logic core_clk_en, periph_clk_en, flash_standby, flash_power_off, sram_retain;
   logic pin_functions_en, lposc_run, wake_timer_run, wake_event, reboot_req;
   logic [7:0]  reg_addr, pin_irq;
   logic [31:0] reg_wdata, reg_rdata, outs;
   int          errors, checked;
   // gating vector: core, periph, standby, off, retain, pins
   assign outs = {26'h0, core_clk_en, periph_clk_en, flash_standby, flash_power_off,
                  sram_retain, pin_functions_en};
   lpwk_ctrl i_dut (.*);
   lpwk_core_model i_core (.*);
   initial begin sys_clk = 0; forever #2 sys_clk = ~sys_clk; end
   // =========================================================
   // access and compare tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin errors++; $display("mismatch at %0t seen %h expected %h", $time, s, e); end
   endtask : chk
   task automatic tick(input int n); repeat (n) @(posedge sys_clk); #1; endtask : tick
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk) reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk) reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd
   task automatic enter(input logic [31:0] p, input logic d, input logic [31:0] e, m);
      wr(8'h00, p);
      i_core.wfi(d);
      tick(2);
      chk(outs & m, e);
   endtask : enter
   // bounded wait for the one-cycle wake pulse
   task automatic wake();
      logic got;
      got = 1'b0;
      for (int i = 0; i < 100 && !got; i++) begin tick(1); got = (wake_event === 1'b1); end
      chk({31'h0, got}, 32'h1);
   endtask : wake
   task automatic wrap_up();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   // watchdog: the tests need well under a thousand cycles
   initial begin repeat (5000) @(posedge sys_clk); errors++; wrap_up(); end
   // =========================================================
   // test sequence
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, resetn} = 0;
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      tick(1);
      chk(outs, 32'h33);
      rd(8'h00, 32'h0);
      enter(32'h0, 1'b0, 32'h13, 32'h3f);
      i_core.set_src(8'h00, 7'h40); wake();
      i_core.set_src(8'h00, 7'h00);
      rd(8'h00, 32'h100);
      wr(8'h00, 32'h100); rd(8'h00, 32'h0);
      $display("sleep test done");
      wr(8'h20, 32'h1);
      enter(32'h1, 1'b1, 32'h0b, 32'h3f);
      i_core.set_src(8'h04, 7'h00); tick(6); chk(outs, 32'h0b);
      i_core.set_src(8'h01, 7'h00); wake();
      i_core.set_src(8'h00, 7'h00);
      wr(8'h2c, 32'h2); wr(8'h28, 32'h1);
      enter(32'h2, 1'b1, 32'h07, 32'h3f);
      i_core.set_src(8'h00, 7'h20); tick(6); chk(outs, 32'h07);
      i_core.set_src(8'h00, 7'h10); wake();
      i_core.set_src(8'h00, 7'h00);
      wr(8'h24, 32'ha); wr(8'h30, 32'h3); wr(8'h28, 32'h3);
      enter(32'h1, 1'b1, 32'h0b, 32'h3f);
      i_core.set_src(8'h00, 7'h02); tick(6); chk(outs, 32'h0b);
      i_core.set_src(8'h00, 7'h03); wake();
      i_core.set_src(8'h00, 7'h00);
      enter(32'h2, 1'b1, 32'h07, 32'h3f);
      i_core.set_src(8'h00, 7'h04); tick(6); chk(outs, 32'h07);
      i_core.set_src(8'h00, 7'h08); wake();
      i_core.set_src(8'h00, 7'h00);
      $display("deep-sleep and power-down tests done");
      wr(8'h04, 32'h5a5a); wr(8'h14, 32'h1);
      enter(32'h3, 1'b1, 32'h00, 32'h33);
      i_core.pin_pulse(); wake();
      rd(8'h04, 32'h5a5a);
      rd(8'h20, 32'h0);
      wr(8'h14, 32'h6); wr(8'h34, 32'h1); wr(8'h38, 32'h3c);
      enter(32'h3, 1'b1, 32'h00, 32'h33);
      chk({30'h0, lposc_run, wake_timer_run}, 32'h3);
      i_core.pin_pulse(); tick(10); chk({31'h0, reboot_req}, 32'h0);
      wake();
      $display("deep power-down tests done");
      enter(32'hb, 1'b1, 32'h13, 32'h3f);
      i_core.set_src(8'h00, 7'h40); wake();
      i_core.set_src(8'h00, 7'h00);
      rd(8'h00, 32'h90b);
      wr(8'h00, 32'h900); rd(8'h00, 32'h8);
      $display("block bit test done");
      wrap_up();
   end
endmodule : tb_lpwk_ctrl
